//--- src/emb_pkg.sv
// package: register map, field layout, reset values and types of the external bus timer
package emb_pkg;
	localparam logic [7:0] EMB_OFS_TIMING = 8'h00;
	localparam logic [7:0] EMB_OFS_CONFIG = 8'h04;
	localparam logic [7:0] EMB_OFS_ADDR = 8'h08;
	localparam logic [7:0] EMB_OFS_DATA = 8'h0c;
	localparam logic [7:0] EMB_OFS_CMD = 8'h10;
	localparam logic [7:0] EMB_TIMING_RESET = 8'hff;
	localparam logic [7:0] EMB_CONFIG_RESET = 8'h03;
	localparam int EMB_SETUP_LSB = 6;
	localparam int EMB_STROBE_LSB = 2;
	localparam int EMB_HOLD_LSB = 0;
	localparam int EMB_MUX_BIT = 4;
	localparam int EMB_LATCH_LSB = 0;
	localparam int EMB_CMD_START_BIT = 0;
	localparam int EMB_CMD_WRITE_BIT = 1;
	localparam logic [4:0] EMB_START_CYCLES = 5'h01;
	localparam logic [4:0] EMB_TAIL_CYCLES = 5'h03;
	localparam logic [4:0] EMB_ONE = 5'h01;
	typedef enum logic [2:0] {
		EMB_IDLE = 3'h0,
		EMB_START = 3'h1,
		EMB_ALE_HI = 3'h3,
		EMB_ALE_LO = 3'h2,
		EMB_SETUP = 3'h6,
		EMB_STROBE = 3'h7,
		EMB_HOLD = 3'h5,
		EMB_TAIL = 3'h4
	} emb_state_t;
	typedef struct packed {
		logic [15:0] addr;
		logic addr_oe;
		logic [7:0] data_out;
		logic data_oe;
		logic rd_n;
		logic wr_n;
		logic ale;
	} emb_pins_t;
endpackage

//--- src/emb_sync.sv
// two-flop synchroniser with asynchronous clear to zero
`timescale 1ns/100ps
module emb_sync #(
	parameter int WIDTH = 1
) (
	input wire logic clock,
	input wire logic rst_n,
	input wire logic [WIDTH-1:0] d,
	output logic [WIDTH-1:0] q
);
	logic [WIDTH-1:0] stage1_reg;
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			stage1_reg <= '0;
			q <= '0;
		end else begin
			stage1_reg <= d;
			q <= stage1_reg;
		end
	end
endmodule // emb_sync

//--- src/emb_timer.sv
// external data-memory bus cycle timer with apb register access
`timescale 1ns/100ps
module emb_timer (
	input wire logic clock,
	input wire logic resetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic [7:0] data_in,
	output emb_pkg::emb_pins_t pins
);
	import emb_pkg::*;

	logic rst_n;
	logic [7:0] data_sync;
	emb_sync #(.WIDTH(1)) u_rst_sync (
		.clock(clock),
		.rst_n(resetn),
		.d(1'b1),
		.q(rst_n)
	);
	emb_sync #(.WIDTH(8)) u_data_sync (
		.clock(clock),
		.rst_n(rst_n),
		.d(data_in),
		.q(data_sync)
	);

	logic [7:0] timing_reg, timing_next;
	logic [7:0] config_reg, config_next;
	logic [15:0] addr_reg, addr_next;
	logic [7:0] wdata_reg, wdata_next;
	logic [7:0] rdata_reg, rdata_next;
	logic dir_write_reg, dir_write_next;
	logic [7:0] dur_reg, dur_next;
	logic [7:0] dur_cnt_reg, dur_cnt_next;
	logic [31:0] prdata_next;
	logic pready_next, pslverr_next;
	emb_state_t state_reg, state_next;
	logic [4:0] cnt_reg, cnt_next;
	logic strobe_end_reg, strobe_end_next;
	logic capture_reg, capture_next;
	emb_pins_t pins_next;

	function automatic logic is_mux(input logic [7:0] cf);
		return ~cf[EMB_MUX_BIT];
	endfunction

	// cycles spent in a phase; zero means the phase is skipped
	function automatic logic [4:0] phase_len(input emb_state_t s, input logic [7:0] tc,
			input logic [7:0] cf);
		case (s)
			EMB_START: phase_len = EMB_START_CYCLES;
			EMB_ALE_HI, EMB_ALE_LO: phase_len = {3'h0, cf[EMB_LATCH_LSB +: 2]} + EMB_ONE;
			EMB_SETUP: phase_len = {3'h0, tc[EMB_SETUP_LSB +: 2]};
			EMB_STROBE: phase_len = {1'b0, tc[EMB_STROBE_LSB +: 4]} + EMB_ONE;
			EMB_HOLD: phase_len = {3'h0, tc[EMB_HOLD_LSB +: 2]};
			EMB_TAIL: phase_len = EMB_TAIL_CYCLES;
			default: phase_len = 5'h00;
		endcase
	endfunction

	// successor phase, skipping phases whose programmed length is zero
	function automatic emb_state_t phase_after(input emb_state_t s, input logic [7:0] tc,
			input logic [7:0] cf);
		case (s)
			EMB_START: begin
				if (is_mux(cf)) begin
					phase_after = EMB_ALE_HI;
				end else if (tc[EMB_SETUP_LSB +: 2] != 2'h0) begin
					phase_after = EMB_SETUP;
				end else begin
					phase_after = EMB_STROBE;
				end
			end
			EMB_ALE_HI: phase_after = EMB_ALE_LO;
			EMB_ALE_LO: begin
				if (tc[EMB_SETUP_LSB +: 2] != 2'h0) begin
					phase_after = EMB_SETUP;
				end else begin
					phase_after = EMB_STROBE;
				end
			end
			EMB_SETUP: phase_after = EMB_STROBE;
			EMB_STROBE: begin
				if (tc[EMB_HOLD_LSB +: 2] != 2'h0) begin
					phase_after = EMB_HOLD;
				end else begin
					phase_after = EMB_TAIL;
				end
			end
			EMB_HOLD: phase_after = EMB_TAIL;
			default: phase_after = EMB_IDLE;
		endcase
	endfunction

	logic apb_access, apb_write, busy, start_req;
	always_comb begin
		apb_access = psel & penable & pready;
		apb_write = apb_access & pwrite;
		busy = (state_reg != EMB_IDLE);
		// refusal is judged once, when pslverr is raised, so the error and the effect agree
		start_req = apb_write & (paddr == EMB_OFS_CMD) & pwdata[EMB_CMD_START_BIT] & ~pslverr;
	end

	// register file; settings are frozen while an access runs so its phases stay coherent
	always_comb begin
		timing_next = timing_reg;
		config_next = config_reg;
		addr_next = addr_reg;
		wdata_next = wdata_reg;
		dir_write_next = dir_write_reg;
		pready_next = psel & penable & ~pready;
		pslverr_next = 1'b0;
		prdata_next = 32'h0000_0000;
		if (psel & penable & ~pready) begin
			case (paddr)
				EMB_OFS_TIMING: begin
					prdata_next = {24'h00_0000, timing_reg};
					pslverr_next = pwrite & busy;
				end
				EMB_OFS_CONFIG: begin
					prdata_next = {24'h00_0000, 3'h0, config_reg[4:0]};
					pslverr_next = pwrite & busy;
				end
				EMB_OFS_ADDR: begin
					prdata_next = {16'h0000, addr_reg};
					pslverr_next = pwrite & busy;
				end
				EMB_OFS_DATA: begin
					prdata_next = {24'h00_0000, rdata_reg};
					pslverr_next = pwrite & busy;
				end
				EMB_OFS_CMD: begin
					prdata_next = {16'h0000, dur_reg, 6'h00, dir_write_reg, busy};
					pslverr_next = pwrite & busy;
				end
				default: pslverr_next = 1'b1;
			endcase
		end
		if (apb_write & ~pslverr) begin
			case (paddr)
				EMB_OFS_TIMING: timing_next = pwdata[7:0];
				EMB_OFS_CONFIG: config_next = {3'h0, pwdata[4:0]};
				EMB_OFS_ADDR: addr_next = pwdata[15:0];
				EMB_OFS_DATA: wdata_next = pwdata[7:0];
				EMB_OFS_CMD: dir_write_next = pwdata[EMB_CMD_WRITE_BIT];
				default: ;
			endcase
		end
	end

	// phase sequencer and pin drive
	always_comb begin
		state_next = state_reg;
		cnt_next = cnt_reg;
		dur_cnt_next = dur_cnt_reg;
		dur_next = dur_reg;
		if (start_req) begin
			state_next = EMB_START;
			cnt_next = phase_len(EMB_START, timing_reg, config_reg);
			dur_cnt_next = 8'h01;
		end else if (busy) begin
			dur_cnt_next = dur_cnt_reg + 8'h01;
			if (cnt_reg == EMB_ONE) begin
				state_next = phase_after(state_reg, timing_reg, config_reg);
				cnt_next = phase_len(state_next, timing_reg, config_reg);
				if (state_reg == EMB_TAIL) begin
					dur_next = dur_cnt_reg;
				end
			end else begin
				cnt_next = cnt_reg - EMB_ONE;
			end
		end
		strobe_end_next = (state_reg == EMB_STROBE) & (cnt_reg == EMB_ONE) & ~dir_write_reg;
		// two-cycle lag of the synchroniser: pin value at strobe end is taken two edges later
		capture_next = strobe_end_reg;
		rdata_next = capture_reg ? data_sync : rdata_reg;
		pins_next.addr = addr_reg;
		pins_next.addr_oe = (state_next != EMB_IDLE);
		pins_next.ale = (state_next == EMB_ALE_HI);
		pins_next.rd_n = ~((state_next == EMB_STROBE) & ~dir_write_reg);
		pins_next.wr_n = ~((state_next == EMB_STROBE) & dir_write_reg);
		if (is_mux(config_reg) & ((state_next == EMB_ALE_HI) | (state_next == EMB_ALE_LO))) begin
			pins_next.data_out = addr_reg[7:0];
			pins_next.data_oe = 1'b1;
		end else begin
			pins_next.data_out = wdata_reg;
			pins_next.data_oe = dir_write_reg & ((state_next == EMB_SETUP) |
				(state_next == EMB_STROBE) | (state_next == EMB_HOLD));
		end
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			timing_reg <= EMB_TIMING_RESET;
			config_reg <= EMB_CONFIG_RESET;
			addr_reg <= 16'h0000;
			wdata_reg <= 8'h00;
			rdata_reg <= 8'h00;
			dir_write_reg <= 1'b0;
			dur_reg <= 8'h00;
			dur_cnt_reg <= 8'h00;
			prdata <= 32'h0000_0000;
			pready <= 1'b0;
			pslverr <= 1'b0;
			state_reg <= EMB_IDLE;
			cnt_reg <= 5'h00;
			strobe_end_reg <= 1'b0;
			capture_reg <= 1'b0;
			pins <= '{addr: 16'h0000, addr_oe: 1'b0, data_out: 8'h00, data_oe: 1'b0,
				rd_n: 1'b1, wr_n: 1'b1, ale: 1'b0};
		end else begin
			timing_reg <= timing_next;
			config_reg <= config_next;
			addr_reg <= addr_next;
			wdata_reg <= wdata_next;
			rdata_reg <= rdata_next;
			dir_write_reg <= dir_write_next;
			dur_reg <= dur_next;
			dur_cnt_reg <= dur_cnt_next;
			prdata <= prdata_next;
			pready <= pready_next;
			pslverr <= pslverr_next;
			state_reg <= state_next;
			cnt_reg <= cnt_next;
			strobe_end_reg <= strobe_end_next;
			capture_reg <= capture_next;
			pins <= pins_next;
		end
	end
endmodule // emb_timer

//--- bench/emb_timer_chk.sv
// port assertions for the bus cycle timer
`timescale 1ns/100ps
module emb_timer_chk (
	input wire logic clock,
	input wire logic resetn,
	input wire emb_pkg::emb_pins_t pins
);
	import emb_pkg::*;
	default clocking @(posedge clock); endclocking
	default disable iff (!resetn);
	go_idle_a: assert property ($rose(pins.addr_oe) |-> pins.rd_n && pins.wr_n)
		else $error("strobe in start cycle");
	lat_byte_a: assert property (pins.ale |-> pins.data_oe && pins.data_out == pins.addr[7:0])
		else $error("latch byte wrong");
	lat_low_a: assert property ($fell(pins.ale) |-> pins.rd_n && pins.wr_n)
		else $error("no latch low phase");
	sep_min_a: assert property ($rose(pins.addr_oe) |-> pins.addr_oe [*5])
		else $error("access too short");
	mux_min_a: assert property ($rose(pins.ale) |-> pins.addr_oe [*6])
		else $error("muxed access too short");
	str_len_a: assert property ($fell(pins.rd_n) |-> ##[1:16] pins.rd_n)
		else $error("strobe too long");
	wr_len_a: assert property ($fell(pins.wr_n) |-> ##[1:16] pins.wr_n)
		else $error("write strobe too long");
	addr_hold_a: assert property (!(pins.rd_n && pins.wr_n) |=> pins.addr_oe)
		else $error("address dropped");
	wr_data_a: assert property (!pins.wr_n |-> pins.data_oe && pins.rd_n)
		else $error("write data off");
	cover property ($fell(pins.ale));
	cover property ($fell(pins.wr_n));
	cover property ($fell(pins.rd_n));
endmodule // emb_timer_chk
bind emb_timer emb_timer_chk chk (.clock(clock), .resetn(resetn), .pins(pins));

//--- bench/emb_mem_model.sv
// far-side byte memory with an address latch
`timescale 1ns/100ps
module emb_mem_model (
	input wire logic clock,
	input wire emb_pkg::emb_pins_t pins,
	output logic [7:0] data_in
);
	import emb_pkg::*;
	logic [7:0] mem [256];
	logic [7:0] lat_reg, junk_reg = 8'h5a;
	logic mux_reg;
	// a released bus toggles so stale read data cannot pass
	assign data_in = pins.rd_n ? junk_reg : mem[mux_reg ? lat_reg : pins.addr[7:0]];
	always @(posedge clock) begin
		junk_reg <= ~junk_reg;
		mux_reg <= pins.ale || (mux_reg && pins.addr_oe);
		if (pins.ale) lat_reg <= pins.data_out;
		if (!pins.wr_n) mem[mux_reg ? lat_reg : pins.addr[7:0]] <= pins.data_out;
	end
endmodule // emb_mem_model

//--- bench/emb_timer_test.sv
// self-checking bench for the bus cycle timer
`timescale 1ns/100ps
module emb_timer_test;
	import emb_pkg::*;
	logic clock = 1'b0, resetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic pready, pslverr, err;
	logic [7:0] paddr = 8'h00, data_in, mem [256];
	logic [31:0] pwdata = 32'h0, prdata, q;
	emb_pins_t pins;
	int failures, n_tests, st, al, cyc;
	emb_timer DUT (.clock(clock), .resetn(resetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .data_in(data_in), .pins(pins));
	emb_mem_model far (.clock(clock), .pins(pins), .data_in(data_in));
	initial forever #12.5 clock = ~clock;
	always @(posedge clock) begin
		st <= st + int'(!(pins.rd_n && pins.wr_n));
		al <= al + int'(pins.ale);
	end
	task automatic check(input string nm, input logic [31:0] got, exp);
		n_tests++;
		if (got !== exp || $isunknown(got)) begin
			failures++;
			$display("BAD %s expected %h seen %h", nm, exp, got);
		end
	endtask
	task automatic give_verdict(input int lost);
		failures += lost;
		$display("checks %0d mismatches %0d", n_tests, failures);
		if (failures == 0 && n_tests > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	task automatic apb(input logic w, input logic [7:0] a, d);
		int n;
		@(posedge clock);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= 32'(d);
		@(posedge clock);
		penable <= 1'b1;
		for (n = 0; n < 9 && pready !== 1'b1; n++)
			@(posedge clock);
		q = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (n > 8) give_verdict(1);
	endtask
	task automatic run(input logic [7:0] cf, tm, input logic wr, input logic [7:0] a, d);
		int s, l, k;
		apb(1'b1, EMB_OFS_CONFIG, cf);
		apb(1'b1, EMB_OFS_TIMING, tm);
		apb(1'b1, EMB_OFS_ADDR, a);
		apb(1'b1, EMB_OFS_DATA, d);
		s = st;
		l = al;
		apb(1'b1, EMB_OFS_CMD, {6'h0, wr, 1'b1});
		apb(1'b1, EMB_OFS_TIMING, 8'h00);
		check("busy write", 32'(err), 32'h1);
		q = 32'h1;
		for (k = 0; k < 20 && q[0] !== 1'b0; k++)
			apb(1'b0, EMB_OFS_CMD, 8'h00);
		if (k > 19) give_verdict(1);
		cyc = int'(q[15:8]);
		check("direction", 32'(q[1]), 32'(wr));
		check("cycles", cyc,
			5 + tm[7:6] + tm[5:2] + tm[1:0] + (cf[4] ? 0 : 2 * cf[1:0] + 2));
		check("strobe", st - s, tm[5:2] + 1);
		check("latch", al - l, cf[4] ? 0 : cf[1:0] + 1);
		apb(1'b0, EMB_OFS_TIMING, 8'h00);
		check("timing kept", q, 32'(tm));
		if (wr) mem[a] = d;
		apb(1'b0, EMB_OFS_DATA, 8'h00);
		if (!wr) check("read byte", q, 32'(mem[a]));
	endtask
	task automatic t_sweep();
		logic [3:0] i;
		for (int n = 0; n < 16; n++) begin
			i = 4'(n);
			run({3'h0, i[1], 2'h0, i[3:2]}, {i[1:0], i, i[3:2]}, !i[0], {4'h0, i[3:1], 1'b1},
				8'(n * 37));
		end
	endtask
	task automatic t_minimum();
		run(8'h10, 8'h00, 1'b1, 8'h20, 8'ha5);
		run(8'h10, 8'h00, 1'b0, 8'h20, 8'h00);
		check("separate min", cyc, 32'h5);
		run(8'h00, 8'h00, 1'b0, 8'h20, 8'h00);
		check("muxed min", cyc, 32'h7);
	endtask
	task automatic t_reset();
		apb(1'b0, EMB_OFS_TIMING, 8'h00);
		check("timing reset", q, 32'hff);
		apb(1'b0, EMB_OFS_CONFIG, 8'h00);
		check("config reset", q, 32'h03);
		apb(1'b0, 8'h14, 8'h00);
		check("unmapped", 32'(err), 32'h1);
	endtask
	initial begin
		repeat (12) @(posedge clock);
		resetn <= 1'b1;
		repeat (3) @(posedge clock);
		t_reset();
		t_minimum();
		t_sweep();
		give_verdict(0);
	end
endmodule // emb_timer_test
